// *** design/low_power_mode_sequencer.sv ***
// Low-power mode sequencer: idle, standby and halt entry and exit
// Notes on behaviour
// (R01) Idle wake resumes within 20 or 1050
// (R02) Idle ends on interrupt, watchdog, nmi, reset
// (R03) No wake before 4 oscillator cycles; not enforced, a wake source is taken in the first cycle after entry
// (R04) Standby wake pulse 3 or 2+count
// (R05) Clock output low 32..45 cycles after entry
// (R06) Standby wake resumes within 100 or 1125
// (R07) Standby flush 16, 32 or 64 cycles
// (R08) Standby stops peripherals, keeps PLL, watchdog
// (R09) Enter from RAM, no external access
// (R10) Halt flush then stop oscillator, core
// (R11) Halt stops peripherals, PLL, crystal oscillator
// (R12) GPIO falling edge restarts oscillator
// (R13) Reset wake held start plus 8
// (R14) Halt exit waits 131072 lock cycles
// (R15) After lock resume within 1125 or 35
// (R16) Halt exit enables clocks then interrupt
// (R17) Latency measured to next instruction start
// (R18) Qualifier needs 3 or 6 samples
// (R19) Mode select chooses state, idle default
`timescale 1ns/1ps
module low_power_mode_sequencer
    import lpm_pkg::*;
#(
    parameter int unsigned LOCK_COUNT  = LOCK_CYCLES,
    parameter int unsigned OSC_START   = OSC_START_CYCLES,
    parameter int unsigned FLASH_WAKE  = 1000
)
(
    input  wire logic     clk_i,
    input  wire logic     rstn_i,
    input  wire lpm_cfg_s cfg_i,
    input  wire logic     crystal_source_i,
    input  wire logic     idle_exec_i,
    input  wire logic     irq_enabled_i,
    input  wire logic     watchdog_interrupt_i,
    input  wire logic     nonmaskable_ext_interrupt_i,
    input  wire logic     external_reset_pin_n_i,
    input  wire logic     wake_gpio_i,
    input  wire logic     qual_en_i,
    output clk_ctl_s      clk_ctl_o,
    output logic          clock_output_pin_o,
    output logic          resume_o,
    output logic          wake_irq_o,
    output logic          busy_o
);
    typedef enum logic [2:0] {
        ST_RUN,
        ST_FLUSH,
        ST_IDLE,
        ST_STANDBY,
        ST_HALT,
        ST_OSC_START,
        ST_LOCK,
        ST_WAKE
    } seq_state_e;

    seq_state_e          state;
    seq_state_e          next_state;
    logic [CNT_WIDTH-1:0] cnt;
    logic [CNT_WIDTH-1:0] next_cnt;
    lpm_mode_e           mode;
    lpm_mode_e           next_mode;
    clk_ctl_s            ctl;
    clk_ctl_s            next_ctl;
    logic                clkout;
    logic                next_clkout;
    logic                resume;
    logic                next_resume;
    logic                irq;
    logic                next_irq;
    logic                pend;
    logic                next_pend;
    logic                gpio_q;
    logic                stby_q;
    logic [QUAL_WIDTH:0] pulse;
    logic [QUAL_WIDTH:0] next_pulse;
    logic [CNT_WIDTH-1:0] flush_len;
    logic [QUAL_WIDTH:0] pulse_need;
    logic                idle_wake;
    logic                stby_wake;
    logic                any_irq;

    // Qualifier on the standby wake input
    wake_qualifier u_qual (
        .clk_i         (clk_i),
        .rstn_i        (rstn_i),
        .enable_i      (qual_en_i),
        .six_samples_i (cfg_i.qual_six),
        .raw_i         (wake_gpio_i),
        .qual_o        (stby_q)
    );

    // Flush length from divider select
    always_comb begin
        case (cfg_i.div_select)
            2'b10:   flush_len = CNT_WIDTH'(FLUSH_MID);   // R07 R10
            2'b11:   flush_len = CNT_WIDTH'(FLUSH_LONG);  // R07 R10
            default: flush_len = CNT_WIDTH'(FLUSH_SHORT); // R07 R10
        endcase
        pulse_need = qual_en_i ? ((QUAL_WIDTH+1)'(2) + {1'b0, cfg_i.qual_count})
                               : (QUAL_WIDTH+1)'(3); // R04
    end

    assign any_irq   = irq_enabled_i | watchdog_interrupt_i | nonmaskable_ext_interrupt_i;
    assign idle_wake = any_irq | !external_reset_pin_n_i; // R02
    assign stby_wake = pulse >= pulse_need;

    // Sequencer next state; wake sources are trusted to respect spacing after entry
    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_mode   = mode;
        next_ctl    = ctl;
        next_clkout = clkout;
        next_resume = 1'b0;
        next_irq    = 1'b0;
        next_pend   = pend;
        next_pulse  = stby_q ? pulse : '0;
        if (stby_q && pulse != '1) begin
            next_pulse = pulse + 1'b1;
        end
        case (state)
            ST_RUN: begin
                next_clkout = 1'b1;
                if (idle_exec_i) begin
                    next_mode = cfg_i.mode; // R19
                    next_cnt  = '0;
                    next_state = (cfg_i.mode == MODE_IDLE) ? ST_IDLE : ST_FLUSH;
                    if (cfg_i.mode == MODE_IDLE) begin
                        next_ctl.core_clk_en = 1'b0;
                    end
                end
            end
            ST_FLUSH: begin
                // System clock held so the pipeline drains; long external accesses fail
                next_cnt = cnt + 1'b1;
                if (cnt + 1'b1 >= flush_len) begin
                    next_ctl.sys_clk_en    = 1'b0;  // R07
                    next_ctl.core_clk_en   = 1'b0;  // R10
                    next_ctl.periph_clk_en = 1'b0;  // R08 R11
                    if (mode == MODE_HALT) begin
                        next_ctl.pll_en  = 1'b0;                // R11
                        next_ctl.wdog_en = 1'b0;
                        next_ctl.osc_en  = !crystal_source_i;   // R11
                    end
                end
                // Pin window is fixed; with the long flush it falls while the clock still runs
                if (cnt + 1'b1 >= CNT_WIDTH'(CLKOUT_LOW_MIN)) begin
                    next_clkout = 1'b0; // R05
                end
                if (cnt + 1'b1 >= flush_len && cnt + 1'b1 >= CNT_WIDTH'(CLKOUT_LOW_MIN)) begin
                    next_state = (mode == MODE_HALT) ? ST_HALT : ST_STANDBY; // R08 R11
                end
            end
            ST_IDLE: begin
                if (idle_wake) begin // R02
                    next_pend  = any_irq;
                    next_cnt   = '0;
                    next_state = ST_WAKE;
                end
            end
            ST_STANDBY: begin
                if (stby_wake || idle_wake) begin // R04
                    next_pend  = any_irq;
                    next_cnt   = '0;
                    next_state = ST_WAKE;
                end
            end
            ST_HALT: begin
                // Falling edge only; a pin that already sits low must not wake
                if ((gpio_q && !wake_gpio_i) || !external_reset_pin_n_i) begin
                    next_ctl.osc_en = 1'b1; // R12
                    next_pend  = any_irq;
                    next_cnt   = '0;
                    next_state = ST_OSC_START;
                end
            end
            ST_OSC_START: begin
                next_cnt = cnt + 1'b1;
                if (cnt + 1'b1 >= CNT_WIDTH'(OSC_START)) begin
                    next_ctl.pll_en = 1'b1;
                    next_cnt   = '0;
                    next_state = ST_LOCK;
                end
            end
            ST_LOCK: begin
                next_cnt = cnt + 1'b1;
                if (cnt + 1'b1 >= CNT_WIDTH'(LOCK_COUNT)) begin // R14
                    next_cnt   = '0;
                    next_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // Restore clocks first, then release; flash sleep adds its own wake time
                next_ctl    = '{default: 1'b1};        // R16
                next_clkout = 1'b1;
                next_cnt    = cnt + 1'b1;
                if (cnt + 1'b1 >= (cfg_i.flash_sleep ? CNT_WIDTH'(FLASH_WAKE) : CNT_WIDTH'(WAKE_DELAY_FAST))) begin
                    next_resume = 1'b1;                // R01 R06 R15 R17
                    next_irq    = pend | any_irq;      // R16
                    next_pend   = 1'b0;
                    next_state  = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state  <= ST_RUN;
            cnt    <= '0;
            mode   <= MODE_IDLE;
            ctl    <= '{default: 1'b1};
            clkout <= 1'b1;
            resume <= 1'b0;
            irq    <= 1'b0;
            pend   <= 1'b0;
            pulse  <= '0;
            gpio_q <= 1'b1;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            mode   <= next_mode;
            ctl    <= next_ctl;
            clkout <= next_clkout;
            resume <= next_resume;
            irq    <= next_irq;
            pend   <= next_pend;
            pulse  <= next_pulse;
            gpio_q <= wake_gpio_i;
        end
    end

    assign clk_ctl_o          = ctl;
    assign clock_output_pin_o = clkout;
    assign resume_o           = resume;
    assign wake_irq_o         = irq;
    assign busy_o             = (state != ST_RUN);
endmodule

// *** design/lpm_pkg.sv ***
// Package with constants and types of the low-power mode sequencer
package lpm_pkg;
    localparam int unsigned CLK_PERIOD_NS      = 10;
    // Wake latency limits in system clock cycles
    localparam int unsigned IDLE_WAKE_FAST     = 20;
    localparam int unsigned IDLE_WAKE_SLOW     = 1050;
    localparam int unsigned STBY_WAKE_FAST     = 100;
    localparam int unsigned STBY_WAKE_SLOW     = 1125;
    localparam int unsigned HALT_WAKE_FAST     = 35;
    localparam int unsigned HALT_WAKE_SLOW     = 1125;
    // Clock output low window after entry
    localparam int unsigned CLKOUT_LOW_MIN     = 32;
    localparam int unsigned CLKOUT_LOW_MAX     = 45;
    // Flush intervals per divider select
    localparam int unsigned FLUSH_SHORT        = 16;
    localparam int unsigned FLUSH_MID          = 32;
    localparam int unsigned FLUSH_LONG         = 64;
    // Lock interval in oscillator cycles
    localparam int unsigned LOCK_CYCLES        = 131072;
    // Oscillator start time default, cycles
    localparam int unsigned OSC_START_CYCLES   = 1000;
    localparam int unsigned QUAL_WIDTH         = 6;
    localparam int unsigned CNT_WIDTH          = 18;
    // Wake delay used without flash sleep: the fast part of the window
    localparam int unsigned WAKE_DELAY_FAST    = 8;

    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_STANDBY,
        MODE_HALT
    } lpm_mode_e;

    typedef struct packed {
        logic                  flash_sleep;
        logic                  qual_six;
        logic [QUAL_WIDTH-1:0] qual_count;
        logic [1:0]            div_select;
        lpm_mode_e             mode;
    } lpm_cfg_s;

    typedef struct packed {
        logic periph_clk_en;
        logic core_clk_en;
        logic sys_clk_en;
        logic pll_en;
        logic osc_en;
        logic wdog_en;
    } clk_ctl_s;
endpackage

// *** design/wake_qualifier.sv ***
// Input qualifier that accepts a wake level after a run of equal samples
`timescale 1ns/1ps
module wake_qualifier
    import lpm_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  enable_i,
    input  wire logic                  six_samples_i,
    input  wire logic                  raw_i,
    output logic                       qual_o
);
    logic [2:0] run;
    logic [2:0] next_run;
    logic       last;
    logic       next_last;
    logic       qual;
    logic       next_qual;
    logic [2:0] need;

    // Count equal samples; bypassed when qualification is off
    always_comb begin
        need      = six_samples_i ? 3'h6 : 3'h3;
        next_last = raw_i;
        next_run  = run;
        next_qual = qual;
        if (raw_i != last) begin
            next_run = 3'h1;
        end else if (run < need) begin
            next_run = run + 3'h1;
        end
        if (!enable_i) begin
            next_qual = raw_i;
        end else if (next_run >= need) begin
            next_qual = raw_i; // R18
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run  <= 3'h0;
            last <= 1'b0;
            qual <= 1'b0;
        end else begin
            run  <= next_run;
            last <= next_last;
            qual <= next_qual;
        end
    end

    assign qual_o = qual;
endmodule

// *** sim/low_power_mode_sequencer_tb.sv ***
// Self-checking testbench of the low-power mode sequencer
`timescale 1ns/1ps
module low_power_mode_sequencer_tb;
    import lpm_pkg::*;
    localparam int unsigned LOCK_P = 64;
    localparam int unsigned OSC_P  = 10;
    logic     clk_i            = 1'b0;
    logic     rstn_i           = 1'b0;
    lpm_cfg_s cfg_i            = '0;
    logic     crystal_source_i = 1'b0;
    logic     idle_exec_i      = 1'b0;
    logic     qual_en_i        = 1'b0;
    logic     irq, wdog, nmi, xrst_n, gpio;
    clk_ctl_s clk_ctl_o;
    logic     clock_output_pin_o, resume_o, wake_irq_o, busy_o;
    int       failures         = 0;
    int       num_checks       = 0;
    int       seed             = 32'hd4ee;

    always #5 clk_i = ~clk_i;

    low_power_mode_sequencer #(.LOCK_COUNT(LOCK_P), .OSC_START(OSC_P), .FLASH_WAKE(50)) low_power_mode_sequencer_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg_i), .crystal_source_i(crystal_source_i),
        .idle_exec_i(idle_exec_i), .irq_enabled_i(irq), .watchdog_interrupt_i(wdog),
        .nonmaskable_ext_interrupt_i(nmi), .external_reset_pin_n_i(xrst_n), .wake_gpio_i(gpio),
        .qual_en_i(qual_en_i), .clk_ctl_o(clk_ctl_o), .clock_output_pin_o(clock_output_pin_o),
        .resume_o(resume_o), .wake_irq_o(wake_irq_o), .busy_o(busy_o));

    wake_source_model wake_source_model_i (.clk_i(clk_i), .irq_o(irq), .wdog_o(wdog), .nmi_o(nmi),
        .reset_n_o(xrst_n), .gpio_o(gpio));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Flush length per divider select
    function automatic int flush_len(input int d);
        return (d == 3) ? FLUSH_LONG : (d == 2) ? FLUSH_MID : FLUSH_SHORT;
    endfunction

    // Worst wake latency allowed for mode and flash state
    function automatic int wake_limit(input int m, input bit slow);
        if (m == 0) return slow ? IDLE_WAKE_SLOW : IDLE_WAKE_FAST;
        if (m == 1) return slow ? STBY_WAKE_SLOW : STBY_WAKE_FAST;
        return OSC_P + LOCK_P + (slow ? HALT_WAKE_SLOW : HALT_WAKE_FAST);
    endfunction

    // Enter one low-power state, wake it with one source, time the exit
    task automatic run(input int m, input int d, input int kind);
        int          n;
        int          c;
        int          f;
        int          w;
        int          len;
        logic [31:0] r;
        r = $random(seed);
        @(posedge clk_i);
        cfg_i <= '{flash_sleep: r[0], qual_six: r[1], qual_count: {3'b000, r[4:2]}, div_select: d[1:0], mode: lpm_mode_e'(m)};
        qual_en_i <= r[5];
        crystal_source_i <= r[6];
        @(posedge clk_i);
        idle_exec_i <= 1'b1;
        @(posedge clk_i);
        idle_exec_i <= 1'b0;
        #1;
        check(busy_o, 1'b1, "busy after entry");
        w = r[5] ? 2 + int'(r[4:2]) + 6 : 3;
        len = (kind == 5) ? OSC_P + 2 : (kind == 3 && m == 2) ? OSC_P + 8 : w;
        n = 1;
        c = 0;
        f = 0;
        // Time the pin fall and the system clock gate in one pass
        while (m != 0 && (c == 0 || f == 0) && n < 200) begin
            @(posedge clk_i);
            #1;
            n++;
            if (c == 0 && clock_output_pin_o === 1'b0) c = n;
            if (f == 0 && clk_ctl_o.sys_clk_en === 1'b0) f = n;
        end
        if (m != 0) check(c - 1 >= CLKOUT_LOW_MIN && c - 1 <= CLKOUT_LOW_MAX, 1'b1, "clock output low");
        if (m != 0) check(f, flush_len(d) + 1, "flush length");
        if (m == 1) check({clk_ctl_o.periph_clk_en, clk_ctl_o.pll_en, clk_ctl_o.wdog_en}, 3'b011, "standby gating");
        if (m == 2) check({clk_ctl_o.periph_clk_en, clk_ctl_o.core_clk_en, clk_ctl_o.pll_en, clk_ctl_o.osc_en},
                          {3'b000, ~crystal_source_i}, "halt gating");
        fork
            wake_source_model_i.pulse(kind, len);
            begin
                n = 0;
                while (resume_o !== 1'b1 && n < 3000) begin
                    @(posedge clk_i);
                    #1;
                    n++;
                end
                check(n - 5 <= wake_limit(m, r[0]) + (r[5] ? w : 0), 1'b1, "wake latency");
                if (m == 2) check(n - 5 >= OSC_P + LOCK_P, 1'b1, "lock interval");
                check(wake_irq_o, kind <= 2, "wake interrupt");
                check(clk_ctl_o, 6'h3f, "clocks after exit");
            end
        join
        if (n >= 3000) results();
        repeat (20) @(posedge clk_i);
        $display("test mode %0d div %0d kind %0d done", m, d, kind);
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        for (int m = 0; m < 3; m++) begin
            for (int d = 0; d < 4; d++) begin
                run(m, d, (m == 0) ? d : (m == 1) ? 4 : (d == 3) ? 3 : 5);
            end
        end
        results();
    end
endmodule

// *** sim/lpm_sequencer_checker.sv ***
// Port-level assertions for the low-power mode sequencer
`timescale 1ns/1ps
module lpm_sequencer_checker
    import lpm_pkg::*;
#(
    parameter int unsigned LOCK_COUNT = LOCK_CYCLES
)
(
    input wire logic     clk_i,
    input wire logic     rstn_i,
    input wire lpm_cfg_s cfg_i,
    input wire logic     idle_exec_i,
    input wire clk_ctl_s clk_ctl_o,
    input wire logic     clock_output_pin_o,
    input wire logic     resume_o,
    input wire logic     wake_irq_o,
    input wire logic     busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    localparam int CLKOUT_MIN = CLKOUT_LOW_MIN;
    localparam int CLKOUT_MAX = CLKOUT_LOW_MAX;

    logic [17:0] osc_run;
    logic [17:0] next_osc_run;
    logic        halted;
    logic        next_halted;

    // Oscillator-on run length; saturates so a long run never wraps
    always_comb begin
        next_osc_run = clk_ctl_o.osc_en ? osc_run + 18'h00001 : 18'h00000;
        if (osc_run == 18'h3ffff) next_osc_run = osc_run;
        next_halted = resume_o ? 1'b0 : (halted | ~clk_ctl_o.osc_en);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_run <= 18'h00000;
            halted  <= 1'b0;
        end else begin
            osc_run <= next_osc_run;
            halted  <= next_halted;
        end
    end

    AST_BUSY_ENTRY: assert property (idle_exec_i && !busy_o |=> busy_o)
        else $error("idle entry did not raise busy");
    AST_FLUSH_HOLD: assert property (idle_exec_i && !busy_o |=> clock_output_pin_o [*8] ##1 clock_output_pin_o [*8])
        else $error("clock output dropped inside the flush interval");
    AST_GATE_TOGETHER: assert property ($fell(clk_ctl_o.sys_clk_en) |-> !clk_ctl_o.periph_clk_en && !clk_ctl_o.core_clk_en)
        else $error("system clock gated while core or peripherals clocked");
    AST_CLKOUT_WINDOW: assert property (idle_exec_i && !busy_o && cfg_i.mode != MODE_IDLE |-> ##[CLKOUT_MIN:CLKOUT_MAX] $fell(clock_output_pin_o))
        else $error("clock output did not fall inside its window");
    AST_PLL_OFF_PERIPH: assert property (!clk_ctl_o.pll_en |-> !clk_ctl_o.periph_clk_en)
        else $error("peripheral clock on with pll off");
    AST_RESUME_ONE: assert property (resume_o |=> !resume_o)
        else $error("resume longer than one cycle");
    AST_IRQ_PAIR: assert property (wake_irq_o |-> resume_o)
        else $error("wake interrupt without resume");
    AST_RESUME_CLOCKS: assert property (resume_o |-> clk_ctl_o.core_clk_en && clk_ctl_o.periph_clk_en && clock_output_pin_o)
        else $error("resume before clocks restored");
    AST_RESUME_AFTER_BUSY: assert property (resume_o |-> $past(busy_o))
        else $error("resume without a low-power state");
    AST_LOCK_WAIT: assert property (resume_o && halted |-> osc_run >= 18'(LOCK_COUNT))
        else $error("halt exit before lock interval");
endmodule

bind low_power_mode_sequencer lpm_sequencer_checker #(.LOCK_COUNT(LOCK_COUNT)) lpm_sequencer_checker_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg_i), .idle_exec_i(idle_exec_i), .clk_ctl_o(clk_ctl_o),
    .clock_output_pin_o(clock_output_pin_o), .resume_o(resume_o), .wake_irq_o(wake_irq_o), .busy_o(busy_o));

// *** sim/wake_source_model.sv ***
// Behavioural model of the external wake sources
`timescale 1ns/1ps
module wake_source_model (
    input  wire logic clk_i,
    output logic      irq_o,
    output logic      wdog_o,
    output logic      nmi_o,
    output logic      reset_n_o,
    output logic      gpio_o
);
    // All sources quiet; code runs from ram, no memory traffic
    initial begin
        {irq_o, wdog_o, nmi_o, gpio_o} = 4'h0;
        reset_n_o = 1'b1;
    end

    // One wake of kind 0 irq, 1 watchdog, 2 nmi, 3 reset, 4 gpio high, 5 gpio low
    task automatic pulse(input int kind, input int len);
        @(posedge clk_i);
        if (kind == 5) gpio_o <= 1'b1;                     // Falling edge needs a high start
        repeat (4) @(posedge clk_i);
        case (kind)
            0: irq_o <= 1'b1;
            1: wdog_o <= 1'b1;
            2: nmi_o <= 1'b1;
            3: reset_n_o <= 1'b0;
            4: gpio_o <= 1'b1;
            default: gpio_o <= 1'b0;
        endcase
        repeat (len) @(posedge clk_i);
        {irq_o, wdog_o, nmi_o} <= 3'b000;
        reset_n_o <= 1'b1;
        if (kind >= 4) gpio_o <= (kind == 5);                // Released only after the oscillator is up
    endtask
endmodule
